// ==== cpurf_core_regs.sv ====
// programmer-visible register set of the 8-bit core
`default_nettype none
`include "cpurf_params.svh"
module cpurf_core_regs
  import cpurf_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // register write port
  input wire logic i_wr_en,
  input wire cpurf_sel_t i_wr_sel,
  input wire logic i_alt_prefix,
  input wire logic [7:0] i_wr_data,
  // program counter update
  input wire logic i_pc_load,
  input wire logic [15:0] i_pc_value,
  // flag update from alu
  input wire logic i_flags_we,
  input wire logic [4:0] i_flags_value,
  // stack operations
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [7:0] i_pop_data,
  input wire logic i_irq_entry,
  input wire logic i_irq_return,
  input wire logic i_call,
  input wire logic i_ret,
  input wire logic i_stack_reinit_op,
  // register contents
  output logic [7:0] o_acc,
  output logic [7:0] o_ptr_x,
  output logic [7:0] o_ptr_y,
  output logic [15:0] o_pc,
  output logic [15:0] o_stack_ptr,
  output logic [7:0] o_condition_flags,
  // stack write side
  output logic o_stk_wr,
  output logic [15:0] o_stk_addr,
  output logic [7:0] o_stk_data,
  output logic o_busy
);
  // six visible registers, reached only through ports
  logic [7:0] acc_reg;
  logic [7:0] x_reg;
  logic [7:0] y_reg;
  logic [7:0] counter_low_byte;
  logic [7:0] counter_high_byte;
  logic [4:0] flags_reg;
  cpurf_state_t state_reg;
  logic [2:0] cnt_reg;
  logic [2:0] idx_reg;
  logic wr_reg;
  logic [15:0] addr_reg;
  logic [7:0] data_reg;
  logic seq_push;
  logic seq_pop;
  logic [7:0] frame_byte;
  logic [7:0] condition_flags;

  cpurf_stk_if stk ();

  // stack pointer unit
  cpurf_stack_ptr u_sp (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .stk(stk)
  );

  assign condition_flags = {`CPURF_FLAGS_ONES, flags_reg};
  assign seq_push = (state_reg == CPURF_ST_PUSH);
  assign seq_pop = (state_reg == CPURF_ST_POP);

  // stack pointer control
  assign stk.push = (state_reg == CPURF_ST_IDLE) ? i_push : seq_push;
  assign stk.pop = (state_reg == CPURF_ST_IDLE) ? i_pop : seq_pop;
  assign stk.reinit = i_stack_reinit_op;
  assign stk.load = i_wr_en && (i_wr_sel == CPURF_SEL_SPL);
  assign stk.load_val = i_wr_data;

  // accumulator, no reset
  always_ff @(posedge i_clock) begin
    if (i_wr_en && i_wr_sel == CPURF_SEL_ACC) begin
      acc_reg <= i_wr_data;
    end else if (seq_pop && idx_reg == 3'h3) begin
      acc_reg <= i_pop_data;
    end
  end

  // pointer registers, prefix picks the second
  always_ff @(posedge i_clock) begin
    if (i_wr_en && i_wr_sel == CPURF_SEL_PTR && !i_alt_prefix) begin
      x_reg <= i_wr_data;
    end else if (seq_pop && idx_reg == 3'h2) begin
      x_reg <= i_pop_data;
    end
  end

  // second pointer is never part of a context frame
  always_ff @(posedge i_clock) begin
    if (i_wr_en && i_wr_sel == CPURF_SEL_PTR && i_alt_prefix) begin
      y_reg <= i_wr_data; // and
    end
  end

  // frame byte order on push: pcl, pch, x, a, flags
  always_comb begin
    unique case (idx_reg)
      3'h0: frame_byte = counter_low_byte;
      3'h1: frame_byte = counter_high_byte;
      3'h2: frame_byte = x_reg;
      3'h3: frame_byte = acc_reg;
      default: frame_byte = condition_flags;
    endcase
  end

  // program counter bytes
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      counter_low_byte <= 8'h00;
      counter_high_byte <= 8'h00;
    end else if (seq_pop && idx_reg == 3'h0) begin
      counter_low_byte <= i_pop_data;
    end else if (seq_pop && idx_reg == 3'h1) begin
      counter_high_byte <= i_pop_data;
    end else if (i_pc_load) begin
      counter_low_byte <= i_pc_value[7:0];
      counter_high_byte <= i_pc_value[15:8];
    end else if (i_wr_en && i_wr_sel == CPURF_SEL_PCL) begin
      counter_low_byte <= i_wr_data;
    end else if (i_wr_en && i_wr_sel == CPURF_SEL_PCH) begin
      counter_high_byte <= i_wr_data;
    end
  end

  // condition flags, mask set on interrupt entry
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      flags_reg <= 5'(`CPURF_FLAGS_RESET);
    end else if (seq_pop && idx_reg == 3'h4) begin
      flags_reg <= i_pop_data[4:0];
    end else if (i_irq_entry && state_reg == CPURF_ST_IDLE) begin
      flags_reg[`CPURF_BIT_MASK] <= 1'b1;
    end else if (i_wr_en && i_wr_sel == CPURF_SEL_FLG) begin
      flags_reg <= i_wr_data[4:0];
    end else if (i_flags_we) begin
      flags_reg <= i_flags_value;
    end
  end

  // frame sequencer: push counts up from pcl, pop counts down to pcl
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_reg <= CPURF_ST_IDLE;
      cnt_reg <= 3'h0;
      idx_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        CPURF_ST_IDLE: begin
          if (i_irq_entry || i_call) begin
            state_reg <= CPURF_ST_PUSH;
            cnt_reg <= i_irq_entry ? `CPURF_IRQ_BYTES : `CPURF_CALL_BYTES;
            idx_reg <= 3'h0;
          end else if (i_irq_return || i_ret) begin
            state_reg <= CPURF_ST_POP;
            cnt_reg <= i_irq_return ? `CPURF_IRQ_BYTES : `CPURF_CALL_BYTES;
            idx_reg <= i_irq_return ? 3'h4 : 3'h1;
          end
        end
        CPURF_ST_PUSH: begin
          idx_reg <= idx_reg + 3'h1;
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h1) begin
            state_reg <= CPURF_ST_IDLE;
          end
        end
        CPURF_ST_POP: begin
          idx_reg <= idx_reg - 3'h1;
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h1) begin
            state_reg <= CPURF_ST_IDLE;
          end
        end
        default: begin
          state_reg <= CPURF_ST_IDLE;
        end
      endcase
    end
  end

  // stack write strobe, registered
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wr_reg <= 1'b0;
      addr_reg <= 16'h0000;
      data_reg <= 8'h00;
    end else begin
      wr_reg <= seq_push;
      addr_reg <= stk.ptr; // written before the decrement
      data_reg <= frame_byte;
    end
  end

  // outputs
  assign o_acc = acc_reg;
  assign o_ptr_x = x_reg;
  assign o_ptr_y = y_reg;
  assign o_pc = {counter_high_byte, counter_low_byte};
  assign o_stack_ptr = stk.ptr;
  assign o_condition_flags = condition_flags;
  assign o_stk_wr = wr_reg;
  assign o_stk_addr = addr_reg;
  assign o_stk_data = data_reg;
  assign o_busy = (state_reg != CPURF_ST_IDLE);
endmodule
`default_nettype wire

// ==== cpurf_params.svh ====
// constants for the core register file
`ifndef CPURF_PARAMS_SVH
`define CPURF_PARAMS_SVH
`define CPURF_SP_RESET 16'h01ff
`define CPURF_SP_HIGH 8'h01
`define CPURF_FLAGS_ONES 3'h7
`define CPURF_FLAGS_RESET 8'he8
`define CPURF_BIT_HALF 4
`define CPURF_BIT_MASK 3
`define CPURF_BIT_NEG 2
`define CPURF_BIT_ZERO 1
`define CPURF_BIT_CARRY 0
`define CPURF_IRQ_BYTES 3'h5
`define CPURF_CALL_BYTES 3'h2
`endif

// ==== cpurf_pkg.sv ====
// types shared by the core register file modules
`default_nettype none
package cpurf_pkg;
  // register selector used by the datapath
  typedef enum logic [2:0] {
    CPURF_SEL_ACC = 3'h0,
    CPURF_SEL_PTR = 3'h1,
    CPURF_SEL_PCL = 3'h2,
    CPURF_SEL_PCH = 3'h3,
    CPURF_SEL_SPL = 3'h4,
    CPURF_SEL_FLG = 3'h5
  } cpurf_sel_t;
  // stack sequencer states
  typedef enum logic [1:0] {
    CPURF_ST_IDLE = 2'h0,
    CPURF_ST_PUSH = 2'h1,
    CPURF_ST_POP = 2'h3
  } cpurf_state_t;
endpackage
`default_nettype wire

// ==== cpurf_stk_if.sv ====
// link between the register file and its stack pointer unit
`default_nettype none
interface cpurf_stk_if;
  logic push;
  logic pop;
  logic reinit;
  logic load;
  logic [7:0] load_val;
  logic [15:0] ptr;
  modport core (output push, pop, reinit, load, load_val, input ptr);
  modport unit (input push, pop, reinit, load, load_val, output ptr);
endinterface
`default_nettype wire

// ==== cpurf_stack_ptr.sv ====
// stack pointer with fixed upper byte and silent wrap
`default_nettype none
`include "cpurf_params.svh"
module cpurf_stack_ptr
  import cpurf_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // control from the register file
  cpurf_stk_if.unit stk
);
  logic [7:0] low_reg;

  // low byte: reset/reinit to top, dec after push, inc before pop
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || stk.reinit) begin
      low_reg <= 8'(`CPURF_SP_RESET);
    end else if (stk.load) begin
      low_reg <= stk.load_val;
    end else if (stk.push) begin
      low_reg <= low_reg - 8'h01;
    end else if (stk.pop) begin
      low_reg <= low_reg + 8'h01;
    end
  end

  assign stk.ptr = {`CPURF_SP_HIGH, low_reg};
endmodule
`default_nettype wire

// ==== cpurf_stack_mem.sv ====
// stack ram model standing where the core's data memory sits
`default_nettype none
module cpurf_stack_mem (
  // clock
  input wire logic i_clock,
  // pushed bytes and pointer from the core
  input wire logic i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic [15:0] i_ptr,
  // byte returned during pops
  output logic [7:0] o_pop_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  // keep each pushed byte
  always_ff @(posedge i_clock) begin
    if (i_wr) begin
      mem[i_addr[7:0]] <= i_data;
    end
  end
  // a pop reads the byte just above the pointer
  assign o_pop_data = mem[8'(i_ptr[7:0] + 8'h01)];
endmodule
`default_nettype wire

// ==== cpurf_core_regs_props.sv ====
// assertions on the core register file ports
`default_nettype none
module cpurf_core_regs_props (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // requests
  input wire logic i_irq_entry,
  input wire logic i_call,
  input wire logic i_push,
  input wire logic i_stack_reinit_op,
  // outputs
  input wire logic o_busy,
  input wire logic o_stk_wr,
  input wire logic [15:0] o_stack_ptr,
  input wire logic [7:0] o_condition_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // accepted sequence starts
  wire irq_go = i_irq_entry && !o_busy;
  wire call_go = i_call && !o_busy && !i_irq_entry;
  wire one_go = !o_busy && !i_irq_entry && !i_call;
  AST_SP_HIGH: assert property (o_stack_ptr[15:8] == 8'h01)
    else $error("stack high byte not fixed");
  AST_FLAG_ONES: assert property (&o_condition_flags[7:5])
    else $error("flag top bits not one");
  AST_REINIT: assert property
    (i_stack_reinit_op && one_go && !i_push |=> o_stack_ptr == 16'h01ff)
    else $error("reinit did not load stack");
  AST_IRQ_BUSY: assert property
    (irq_go |=> o_busy [*5] ##1 !o_busy) else $error("irq length wrong");
  AST_CALL_BUSY: assert property
    (call_go |=> o_busy [*2] ##1 !o_busy) else $error("call length wrong");
  AST_IRQ_WR: assert property
    (irq_go |=> ##1 o_stk_wr [*5] ##1 !o_stk_wr) else $error("push count");
  AST_IRQ_MASK: assert property
    (irq_go |=> o_condition_flags[3]) else $error("mask not set on irq");
  AST_IRQ_SP: assert property (irq_go |=> ##5
    8'(o_stack_ptr + 16'h5) == 8'($past(o_stack_ptr, 6)))
    else $error("irq stack step wrong");
  AST_PUSH_STEP: assert property (i_push && one_go &&
    !i_stack_reinit_op |=> 8'(o_stack_ptr + 16'h1) == 8'($past(o_stack_ptr)))
    else $error("push step wrong");
  // main scenarios reached
  cover property (irq_go);
  cover property (call_go);
  cover property (i_stack_reinit_op);
endmodule
`default_nettype wire

// ==== cpurf_tb.sv ====
// self-checking bench for the core register file
`default_nettype none
module tb
  import cpurf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_wr_en = 1'b0;
  logic i_alt_prefix = 1'b0;
  logic i_pc_load = 1'b0;
  logic i_flags_we = 1'b0;
  logic [6:0] req = 7'h00;
  cpurf_sel_t i_wr_sel = CPURF_SEL_ACC;
  logic [7:0] i_wr_data = 8'h00;
  logic [15:0] i_pc_value = 16'h0000;
  logic [4:0] i_flags_value = 5'h00;
  logic [7:0] i_pop_data, o_acc, o_ptr_x, o_ptr_y, o_condition_flags;
  logic [7:0] o_stk_data;
  logic [15:0] o_pc, o_stack_ptr, o_stk_addr;
  logic o_stk_wr, o_busy;
  // strobes: 0 push 1 pop 2 call 3 ret 4 irq 5 irq return 6 reinit
  wire i_push = req[0], i_pop = req[1], i_call = req[2], i_ret = req[3];
  wire i_irq_entry = req[4], i_irq_return = req[5];
  wire i_stack_reinit_op = req[6];
  logic [7:0] seen [$];
  logic [15:0] seen_a [$];
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  cpurf_core_regs DUT (.*);
  cpurf_stack_mem u_mem (
    .i_clock(i_clock),
    .i_wr(o_stk_wr),
    .i_addr(o_stk_addr),
    .i_data(o_stk_data),
    .i_ptr(o_stack_ptr),
    .o_pop_data(i_pop_data)
  );
  always #5 i_clock = ~i_clock;
  // record pushed bytes; cut a hang short
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (o_stk_wr === 1'b1) begin
      seen.push_back(o_stk_data);
      seen_a.push_back(o_stk_addr);
    end
    if (cyc == 2000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input cpurf_sel_t s, input logic a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr_en <= 1'b1;
    i_wr_sel <= s;
    i_alt_prefix <= a;
    i_wr_data <= d;
    @(posedge i_clock);
    i_wr_en <= 1'b0;
    @(negedge i_clock);
  endtask
  task automatic pulse(input int b);
    @(posedge i_clock);
    req[b] <= 1'b1;
    @(posedge i_clock);
    req <= 7'h00;
    @(posedge i_clock);
    for (int k = 0; k < 8 && o_busy === 1'b1; k++) begin
      @(posedge i_clock);
    end
    @(negedge i_clock);
  endtask
  task automatic load_pc_flags(input logic [15:0] p, input logic [4:0] f);
    @(posedge i_clock);
    i_pc_load <= 1'b1;
    i_pc_value <= p;
    i_flags_we <= 1'b1;
    i_flags_value <= f;
    @(posedge i_clock);
    i_pc_load <= 1'b0;
    i_flags_we <= 1'b0;
    @(negedge i_clock);
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    @(negedge i_clock);
    chk(o_stack_ptr, 16'h01ff);
    chk(o_condition_flags, 8'he8);
    wr(CPURF_SEL_ACC, 1'b0, 8'ha5);
    wr(CPURF_SEL_PTR, 1'b0, 8'h3c);
    wr(CPURF_SEL_PTR, 1'b1, 8'hc3);
    wr(CPURF_SEL_PCL, 1'b0, 8'h34);
    wr(CPURF_SEL_PCH, 1'b0, 8'h12);
    wr(CPURF_SEL_FLG, 1'b0, 8'h15);
    chk({o_acc, o_ptr_x}, 16'ha53c);
    chk({o_ptr_y, o_ptr_x}, 16'hc33c);
    chk(o_pc, 16'h1234);
    chk(o_condition_flags, 8'hf5);
    pulse(4);
    chk(o_stack_ptr, 16'h01fa);
    chk({seen[0], seen[1]}, 16'h3412);
    chk({seen[2], seen[3]}, 16'h3ca5);
    chk(16'(seen.size()), 16'h0005);
    chk(seen_a[0], 16'h01ff);
    chk(seen_a[4], 16'h01fb);
    wr(CPURF_SEL_ACC, 1'b0, 8'h00);
    wr(CPURF_SEL_PTR, 1'b0, 8'h00);
    wr(CPURF_SEL_PTR, 1'b1, 8'h77);
    wr(CPURF_SEL_PCL, 1'b0, 8'h00);
    pulse(5);
    chk({o_acc, o_ptr_x}, 16'ha53c);
    chk({o_ptr_y, o_stack_ptr[7:0]}, 16'h77ff);
    chk(o_pc, 16'h1234);
    seen.delete();
    seen_a.delete();
    pulse(2);
    chk(o_stack_ptr, 16'h01fd);
    chk({seen[0], 8'(seen.size())}, 16'h3402);
    chk(seen_a[1], 16'h01fe);
    wr(CPURF_SEL_PCL, 1'b0, 8'h00);
    pulse(3);
    chk(o_pc, 16'h1234);
    pulse(1);
    chk(o_stack_ptr, 16'h0100);
    pulse(0);
    pulse(0);
    chk(o_stack_ptr, 16'h01fe);
    pulse(6);
    chk(o_stack_ptr, 16'h01ff);
    // low stack byte written directly, high byte stays fixed
    wr(CPURF_SEL_SPL, 1'b0, 8'h80);
    chk(o_stack_ptr, 16'h0180);
    // whole counter load and alu flag update
    load_pc_flags(16'habcd, 5'h0a);
    chk(o_pc, 16'habcd);
    chk(o_condition_flags, 8'hea);
    // second reset in mid-run
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    @(posedge i_clock);
    i_sys_rst <= 1'b0;
    @(negedge i_clock);
    chk(o_stack_ptr, 16'h01ff);
    chk(o_condition_flags, 8'he8);
    chk(o_pc, 16'h0000);
    chk(16'(o_busy), 16'h0000);
    pulse(0);
    chk(o_stack_ptr, 16'h01fe);
    report_and_stop();
  end
endmodule
bind cpurf_core_regs cpurf_core_regs_props u_props (.*);
`default_nettype wire
